// ===== rtl/fifo_ofs_map.svh
// fifo_ofs_map.svh - offset register sequence, defaults and synchroniser depth
// assumes: included by the offset/replay FIFO files, definitions only
`ifndef FIFO_OFS_MAP_SVH
`define FIFO_OFS_MAP_SVH

// positions of the offset registers in the load/readback sequence
`define OFS_EMPTY_LO 2'h0
`define OFS_EMPTY_HI 2'h1
`define OFS_FULL_LO  2'h2
`define OFS_FULL_HI  2'h3

// default thresholds chosen by the load select strap at full reset
`define OFS_DEF_PARALLEL 18'h0007F
`define OFS_DEF_SERIAL   18'h003FF

// synchroniser depth for pin inputs
`define SYNC_STAGES 2

`endif

// ===== rtl/fifo_ofs_pkg.sv
// fifo_ofs_pkg - types shared by the offset/replay FIFO
// assumes: nothing beyond the map header for numbers
package fifo_ofs_pkg;

  // replay sequence: idle, rewind, then in fall-through mode present the first word
  typedef enum logic [2:0] {
    RP_IDLE  = 3'b001,
    RP_SETUP = 3'b010,
    RP_LOAD  = 3'b100
  } replay_state_e;

  typedef logic [1:0] ofs_ptr_t;

endpackage

// ===== rtl/pin_sync.sv
// pin_sync - two flip-flop synchroniser for a group of pin inputs
// assumes: all bits are sampled together, outputs read only downstream
`timescale 1ns/1ps
`include "fifo_ofs_map.svh"
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // async reset, active high
  input  wire logic [W-1:0] d,     // raw pin levels
  output logic      [W-1:0] q      // levels after two flops
);
  logic [W-1:0] stage [`SYNC_STAGES];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `SYNC_STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= d;
      for (int i = 1; i < `SYNC_STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign q = stage[`SYNC_STAGES-1];
endmodule

// ===== rtl/fifo_mem.sv
// fifo_mem - simple dual-port word store with registered read data
// assumes: one clock, write and read may hit the same word in one cycle
`timescale 1ns/1ps
module fifo_mem #(
  parameter int DATA_W = 9,
  parameter int ADDR_W = 14
) (
  input  wire logic              clk,      // system clock
  input  wire logic              wr_en,    // write strobe, one cycle
  input  wire logic [ADDR_W-1:0] wr_addr,  // write address
  input  wire logic [DATA_W-1:0] wr_data,  // write word
  input  wire logic [ADDR_W-1:0] rd_addr,  // read address
  output logic      [DATA_W-1:0] rd_data   // word at rd_addr, one cycle late
);
  logic [DATA_W-1:0] store [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  // no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    rd_data <= store[rd_addr];
  end
endmodule

// ===== rtl/fifo_offset_load_and_replay.sv
// fifo_offset_load_and_replay - FIFO with parallel offset load/readback
// and replay of stored data from the first location.
// assumes: write and read clocks arrive as pins far slower than clk,
// so each of their rising edges is seen as a one-cycle enable here.
`timescale 1ns/1ps
`include "fifo_ofs_map.svh"
module fifo_offset_load_and_replay #(
  parameter int DATA_W = 9,
  parameter int ADDR_W = 14
) (
  input  wire logic              clk,                   // system clock, 50 MHz
  input  wire logic              sys_rst,               // async reset, active high
  input  wire logic              write_clk,             // producer clock pin
  input  wire logic              write_strobe_n,        // write enable, low active
  input  wire logic              offset_load_select_n,  // offset access select
  input  wire logic [DATA_W-1:0] write_data_bus,        // write data
  input  wire logic              read_clk,              // consumer clock pin
  input  wire logic              read_strobe_n,         // read enable, low active
  input  wire logic              replay_request_n,      // replay setup request
  input  wire logic              fall_through_select,   // mode strap
  input  wire logic              full_reset_n,          // full reset pin
  input  wire logic              partial_reset_n,       // partial reset pin
  output logic      [DATA_W-1:0] read_data_bus,         // read data
  output logic                   empty_flag_n,          // empty, or not-ready
  output logic                   full_flag_n,           // full, or no-space
  output logic                   half_full_flag_n,      // more than half full
  output logic                   almost_empty_flag_n,   // at or below empty offset
  output logic                   almost_full_flag_n,    // within full offset of full
  output logic                   fall_through_mode,     // mode latched at full reset
  output logic                   parallel_load_mode     // offset method latched
);
  localparam int                PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0]  DEPTH = PTR_W'(2 ** ADDR_W);
  localparam logic [PTR_W-1:0]  HALF  = PTR_W'(2 ** (ADDR_W - 1));

  // offset word assembled from a low and a high register
  function automatic logic [PTR_W-1:0] ofs_value(input logic [DATA_W-1:0] lo,
                                                 input logic [DATA_W-1:0] hi);
    logic [2*DATA_W-1:0] both;
    both      = {hi, lo};
    ofs_value = {1'b0, both[ADDR_W-1:0]};
  endfunction

  // default offset for the method chosen by the strap
  function automatic logic [2*DATA_W-1:0] ofs_default(input logic parallel);
    ofs_default = parallel ? (2*DATA_W)'(`OFS_DEF_PARALLEL)
                           : (2*DATA_W)'(`OFS_DEF_SERIAL);
  endfunction

  // pin inputs, each group through two flip-flops
  logic [DATA_W+2:0] w_s;
  logic [6:0]        r_s;

  pin_sync #(.W(DATA_W + 3)) u_wsync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({write_clk, write_strobe_n, offset_load_select_n, write_data_bus}),
    .q   (w_s)
  );

  pin_sync #(.W(7)) u_rsync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({read_clk, read_strobe_n, offset_load_select_n, replay_request_n,
           fall_through_select, full_reset_n, partial_reset_n}),
    .q   (r_s)
  );

  logic              wclk_s;
  logic              wen_n;
  logic              wld_n;
  logic [DATA_W-1:0] wdata;
  logic              rclk_s;
  logic              ren_n;
  logic              rld_n;
  logic              rt_n;
  logic              fts;
  logic              full_rst;
  logic              any_rst;

  assign wclk_s   = w_s[DATA_W+2];
  assign wen_n    = w_s[DATA_W+1];
  assign wld_n    = w_s[DATA_W];
  assign wdata    = w_s[DATA_W-1:0];
  assign rclk_s   = r_s[6];
  assign ren_n    = r_s[5];
  assign rld_n    = r_s[4];
  assign rt_n     = r_s[3];
  assign fts      = r_s[2];
  assign full_rst = ~r_s[1];
  assign any_rst  = ~r_s[1] | ~r_s[0];

  // edge detection looks only at synchronised levels
  logic wclk_d;
  logic rclk_d;
  logic w_edge;
  logic r_edge;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      wclk_d <= wclk_s;
      rclk_d <= rclk_s;
    end
  end

  assign w_edge = wclk_s & ~wclk_d;
  assign r_edge = rclk_s & ~rclk_d;

  // mode straps sampled while the full reset is held
  logic mode_now;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_through_mode  <= 1'b0;
      parallel_load_mode <= 1'b1;
    end else if (full_rst) begin
      fall_through_mode  <= fts;
      parallel_load_mode <= ~rld_n;
    end
  end

  assign mode_now = full_rst ? fts : fall_through_mode;

  // offset registers and their two sequence pointers
  logic [DATA_W-1:0]     ofs_reg [4];
  fifo_ofs_pkg::ofs_ptr_t ofs_wptr;
  fifo_ofs_pkg::ofs_ptr_t ofs_rptr;
  logic                  ae_valid;
  logic                  af_valid;
  logic                  ofs_write;
  logic [2*DATA_W-1:0]   def_ofs;

  assign ofs_write = w_edge & ~wld_n & ~wen_n & parallel_load_mode;
  assign def_ofs   = ofs_default(~rld_n);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        ofs_reg[i] <= '0;
      end
      ofs_wptr <= `OFS_EMPTY_LO;
    end else if (full_rst) begin
      ofs_wptr                <= `OFS_EMPTY_LO;
      ofs_reg[`OFS_EMPTY_LO] <= def_ofs[DATA_W-1:0];
      ofs_reg[`OFS_EMPTY_HI] <= def_ofs[2*DATA_W-1:DATA_W];
      ofs_reg[`OFS_FULL_LO]  <= def_ofs[DATA_W-1:0];
      ofs_reg[`OFS_FULL_HI]  <= def_ofs[2*DATA_W-1:DATA_W];
    end else if (ofs_write) begin
      ofs_reg[ofs_wptr] <= wdata;
      ofs_wptr          <= ofs_wptr + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ae_valid <= 1'b1;
      af_valid <= 1'b1;
    end else if (full_rst) begin
      ae_valid <= 1'b1;
      af_valid <= 1'b1;
    end else if (ofs_write) begin
      if (ofs_wptr == `OFS_EMPTY_LO) begin
        ae_valid <= 1'b0;
      end
      if (ofs_wptr == `OFS_EMPTY_HI) begin
        ae_valid <= 1'b1;
      end
      if (ofs_wptr == `OFS_FULL_LO) begin
        af_valid <= 1'b0;
      end
      if (ofs_wptr == `OFS_FULL_HI) begin
        af_valid <= 1'b1;
      end
    end
  end

  // data path pointers; the extra bit tells full from empty
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  logic [PTR_W-1:0]  count;
  logic              mem_we;
  logic [DATA_W-1:0] mem_q;

  assign count = wr_ptr - rd_ptr;
  assign mem_we = w_edge & wld_n & ~wen_n & (count != DEPTH);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (any_rst) begin
      wr_ptr <= '0;
    end else if (mem_we) begin
      wr_ptr <= wr_ptr + PTR_W'(1);
    end
  end

  fifo_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (wr_ptr[ADDR_W-1:0]),
    .wr_data (wdata),
    .rd_addr (rd_ptr[ADDR_W-1:0]),
    .rd_data (mem_q)
  );

  // read side: memory reads, offset readback and replay
  fifo_ofs_pkg::replay_state_e rstate;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ofs_rptr <= `OFS_EMPTY_LO;
    end else if (full_rst) begin
      ofs_rptr <= `OFS_EMPTY_LO;
    end else if (r_edge && rstate == fifo_ofs_pkg::RP_IDLE && rt_n && !rld_n
                 && !ren_n) begin
      ofs_rptr <= ofs_rptr + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr        <= '0;
      read_data_bus <= '0;
      empty_flag_n  <= 1'b0;
      rstate        <= fifo_ofs_pkg::RP_IDLE;
    end else if (any_rst) begin
      rd_ptr        <= '0;
      read_data_bus <= '0;
      empty_flag_n  <= mode_now;
      rstate        <= fifo_ofs_pkg::RP_IDLE;
    end else if (r_edge) begin
      unique case (rstate)
        fifo_ofs_pkg::RP_IDLE: begin
          if (!rt_n) begin
            rd_ptr       <= '0;
            empty_flag_n <= fall_through_mode;
            rstate       <= fifo_ofs_pkg::RP_SETUP;
          end else if (!rld_n && !ren_n) begin
            read_data_bus <= ofs_reg[ofs_rptr];
          end else if (rld_n && fall_through_mode) begin
            // word falls through when outputs are free
            if (empty_flag_n || !ren_n) begin
              if (count != '0) begin
                read_data_bus <= mem_q;
                rd_ptr        <= rd_ptr + PTR_W'(1);
                empty_flag_n  <= 1'b0;
              end else begin
                empty_flag_n  <= 1'b1;
              end
            end
          end else if (rld_n) begin
            if (!ren_n && count != '0) begin
              read_data_bus <= mem_q;
              rd_ptr        <= rd_ptr + PTR_W'(1);
              empty_flag_n  <= (count != PTR_W'(1));
            end else begin
              empty_flag_n  <= (count != '0);
            end
          end
        end
        fifo_ofs_pkg::RP_SETUP: begin
          // one edge lets the store present the first location
          rstate <= fifo_ofs_pkg::RP_LOAD;
        end
        fifo_ofs_pkg::RP_LOAD: begin
          if (fall_through_mode) begin
            read_data_bus <= mem_q;
            rd_ptr        <= rd_ptr + PTR_W'(1);
            empty_flag_n  <= 1'b0;
          end else begin
            empty_flag_n  <= (count != '0);
          end
          rstate <= fifo_ofs_pkg::RP_IDLE;
        end
      endcase
    end
  end

  // full / space flag, write side
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_flag_n <= 1'b1;
    end else if (any_rst) begin
      full_flag_n <= ~mode_now;
    end else if (w_edge) begin
      full_flag_n <= fall_through_mode ? (count == DEPTH) : (count != DEPTH);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_full_flag_n <= 1'b1;
    end else if (any_rst) begin
      half_full_flag_n <= 1'b1;
    end else begin
      half_full_flag_n <= ~(count > HALF);
    end
  end

  // partial flags pass two edges of their own clock
  logic [PTR_W-1:0] ae_ofs;
  logic [PTR_W-1:0] af_ofs;
  logic             ae_stage;
  logic             af_stage;

  assign ae_ofs = ofs_value(ofs_reg[`OFS_EMPTY_LO], ofs_reg[`OFS_EMPTY_HI]);
  assign af_ofs = ofs_value(ofs_reg[`OFS_FULL_LO], ofs_reg[`OFS_FULL_HI]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ae_stage            <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else if (any_rst) begin
      ae_stage            <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else if (r_edge && ae_valid) begin
      ae_stage            <= (count > ae_ofs);
      almost_empty_flag_n <= ae_stage;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      af_stage           <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else if (any_rst) begin
      af_stage           <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else if (w_edge && af_valid) begin
      af_stage           <= (count < (DEPTH - af_ofs));
      almost_full_flag_n <= af_stage;
    end
  end
endmodule

// ===== verif/fifo_offset_load_and_replay_asserts.sv
// port checker for the offset/replay FIFO
// assumes: pin clocks slow against clk, reset pins held low >= 6 clk
`timescale 1ns/1ps
module fifo_offset_load_and_replay_asserts #(
  parameter int DATA_W = 9,
  parameter int ADDR_W = 14
) (
  input wire logic              clk,                   // system clock
  input wire logic              sys_rst,               // async reset
  input wire logic              write_clk,             // producer clock pin
  input wire logic              write_strobe_n,        // write enable
  input wire logic              offset_load_select_n,  // offset select
  input wire logic              read_clk,              // consumer clock pin
  input wire logic              read_strobe_n,         // read enable
  input wire logic              replay_request_n,      // replay request
  input wire logic              fall_through_select,   // mode strap
  input wire logic              full_reset_n,          // full reset pin
  input wire logic              partial_reset_n,       // partial reset pin
  input wire logic [DATA_W-1:0] read_data_bus,         // read data
  input wire logic              empty_flag_n,          // empty or not-ready
  input wire logic              almost_empty_flag_n,   // almost empty
  input wire logic              almost_full_flag_n,    // almost full
  input wire logic              fall_through_mode,     // latched mode
  input wire logic              parallel_load_mode     // latched method
);
  logic [3:0] rd_age;
  logic [3:0] wr_age;
  logic [3:0] rst_age;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ages saturate so a stale edge never excuses a change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_age  <= 4'hF;
      wr_age  <= 4'hF;
      rst_age <= 4'h0;
    end else begin
      rd_age  <= $rose(read_clk) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
      wr_age  <= $rose(write_clk) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
      rst_age <= (!full_reset_n || !partial_reset_n) ? 4'h0 : rst_age + {3'h0, rst_age != 4'hF};
    end
  end
  mode_latch_a: assert property ((!full_reset_n)[*6] |-> fall_through_mode == $past(fall_through_select, 3)) else $error("mode not latched from strap");
  load_method_a: assert property ((!full_reset_n)[*6] |-> parallel_load_mode == !$past(offset_load_select_n, 3)) else $error("load method not latched");
  partial_clear_a: assert property ((!partial_reset_n)[*6] |-> read_data_bus == '0 && !almost_empty_flag_n && almost_full_flag_n) else $error("partial reset outputs wrong");
  rdata_cause_a: assert property ($changed(read_data_bus) |-> rd_age <= 4'h6 || rst_age <= 4'h8) else $error("read data moved without read edge");
  ae_cause_a: assert property ($changed(almost_empty_flag_n) |-> rd_age <= 4'h6 || rst_age <= 4'h8) else $error("almost empty moved off read edge");
  af_cause_a: assert property ($changed(almost_full_flag_n) |-> wr_age <= 4'h6 || rst_age <= 4'h8) else $error("almost full moved off write edge");
  replay_std_a: assert property ($rose(read_clk) && !replay_request_n && read_strobe_n && write_strobe_n && !fall_through_mode && rst_age > 4'h8 |-> ##[2:6] !empty_flag_n) else $error("replay setup not marked by empty");
  replay_ft_a: assert property ($rose(read_clk) && !replay_request_n && read_strobe_n && write_strobe_n && fall_through_mode && rst_age > 4'h8 |-> ##[2:6] empty_flag_n) else $error("replay setup not marked by not-ready");
  cover property ($rose(read_clk) && !replay_request_n && !fall_through_mode);
  cover property ($rose(read_clk) && !replay_request_n && fall_through_mode);
  cover property ($rose(read_clk) && !offset_load_select_n && !read_strobe_n);
endmodule
bind fifo_offset_load_and_replay fifo_offset_load_and_replay_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_i (.clk, .sys_rst, .write_clk, .write_strobe_n, .offset_load_select_n, .read_clk, .read_strobe_n, .replay_request_n, .fall_through_select, .full_reset_n, .partial_reset_n, .read_data_bus, .empty_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .fall_through_mode, .parallel_load_mode);

// ===== verif/fifo_pin_host.sv
// producer/consumer pin driver for the offset/replay FIFO
// assumes: pins move on the falling edge of clk, pin clocks 10 clk long
`timescale 1ns/1ps
module fifo_pin_host (
  input  wire logic clk,                   // system clock
  output logic       write_clk,             // producer clock pin
  output logic       write_strobe_n,        // write enable
  output logic       offset_load_select_n,  // offset select
  output logic [8:0] write_data_bus,        // write data
  output logic       read_clk,              // consumer clock pin
  output logic       read_strobe_n,         // read enable
  output logic       replay_request_n       // replay request
);
  logic sel_idle;
  initial begin
    {write_clk, read_clk} = 2'h0;
    {write_strobe_n, read_strobe_n, replay_request_n, offset_load_select_n, sel_idle} = 5'h1F;
    write_data_bus = 9'h000;
  end
  task automatic idle_sel(input logic v);
    sel_idle = v;
    offset_load_select_n = v;
  endtask
  // only one offset access at a time
  task automatic wr(input logic s_n, input logic l_n, input logic [8:0] d);
    write_strobe_n = s_n;
    offset_load_select_n = l_n;
    write_data_bus = d;
    repeat (2) @(negedge clk);
    write_clk = 1'b1;
    repeat (4) @(negedge clk);
    write_clk = 1'b0;
    write_strobe_n = 1'b1;
    offset_load_select_n = sel_idle;
    // released bus shows the inverse, not the old word
    write_data_bus = ~d;
    repeat (4) @(negedge clk);
  endtask
  // write strobe is idle high whenever a read edge runs
  task automatic rd(input logic s_n, input logic l_n, input logic r_n);
    read_strobe_n = s_n;
    offset_load_select_n = l_n;
    replay_request_n = r_n;
    repeat (2) @(negedge clk);
    read_clk = 1'b1;
    repeat (4) @(negedge clk);
    read_clk = 1'b0;
    read_strobe_n = 1'b1;
    replay_request_n = 1'b1;
    offset_load_select_n = sel_idle;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ===== verif/fifo_offset_load_and_replay_tb_top.sv
// self-checking bench for the offset/replay FIFO
// assumes: fifo_pin_host drives the pins, model kept here with queues
`timescale 1ns/1ps
module fifo_offset_load_and_replay_tb_top;
  logic       clk, sys_rst, full_reset_n, partial_reset_n, fall_through_select;
  logic       write_clk, write_strobe_n, offset_load_select_n, read_clk;
  logic       read_strobe_n, replay_request_n, ft;
  logic [8:0] write_data_bus, rd_bus, ofs[4], mem[$];
  logic       ef_n, ff_n, hf_n, ae_n, af_n, ft_mode, par_mode;
  logic [15:0] seed;
  int         failures, check_count, rdp, wp, rp;
  fifo_pin_host host (.clk, .write_clk, .write_strobe_n, .offset_load_select_n,
    .write_data_bus, .read_clk, .read_strobe_n, .replay_request_n);
  fifo_offset_load_and_replay DUT (.clk, .sys_rst, .write_clk, .write_strobe_n,
    .offset_load_select_n, .write_data_bus, .read_clk, .read_strobe_n, .replay_request_n,
    .fall_through_select, .full_reset_n, .partial_reset_n, .read_data_bus(rd_bus),
    .empty_flag_n(ef_n), .full_flag_n(ff_n), .half_full_flag_n(hf_n),
    .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .fall_through_mode(ft_mode),
    .parallel_load_mode(par_mode));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rst(input logic full, input logic strap);
    fall_through_select = strap;
    host.idle_sel(1'b0);
    @(negedge clk);
    if (full) full_reset_n = 1'b0;
    else partial_reset_n = 1'b0;
    repeat (6) @(negedge clk);
    full_reset_n = 1'b1;
    partial_reset_n = 1'b1;
    repeat (10) @(negedge clk);
    host.idle_sel(1'b1);
    mem.delete();
    rdp = 0;
    if (full) begin
      wp = 0;
      rp = 0;
      ofs = '{9'h07F, 9'h000, 9'h07F, 9'h000};
      ft = strap;
    end
  endtask
  // maximal-length taps, never reaches the all-zero lock-up state
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic mwr;
    seed = lfsr_next(seed);
    host.wr(1'b0, 1'b1, seed[8:0]);
    mem.push_back(seed[8:0]);
  endtask
  task automatic mrd;
    host.rd(1'b0, 1'b1, 1'b1);
    if (ft) rdp++;
    chk(rd_bus, mem[rdp]);
    if (!ft) rdp++;
  endtask
  task automatic owr(input logic [8:0] d);
    host.wr(1'b0, 1'b0, d);
    ofs[wp] = d;
    wp = (wp + 1) % 4;
  endtask
  task automatic ord;
    host.rd(1'b0, 1'b0, 1'b1);
    chk(rd_bus, ofs[rp]);
    rp = (rp + 1) % 4;
  endtask
  task automatic replay;
    host.rd(1'b1, 1'b1, 1'b0);
    chk(ef_n, ft);
    repeat (2) host.rd(1'b1, 1'b1, 1'b1);
    rdp = 0;
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    seed = 16'h301B;
    ft = 1'b0;
    sys_rst = 1'b1;
    {full_reset_n, partial_reset_n, fall_through_select} = 3'h6;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    rst(1'b1, 1'b0);
    chk(par_mode, 1'b1);
    chk(ft_mode, 1'b0);
    $display("test reset done");
    owr(seed[8:0]);
    owr(9'h000);
    mwr();
    host.wr(1'b1, 1'b0, 9'h155);
    owr(9'h1FF);
    owr(9'h01F);
    owr(9'h000);
    // finish the empty offset again so almost-empty is valid when checked
    owr(9'h000);
    repeat (2) ord();
    host.rd(1'b1, 1'b0, 1'b1);
    mrd();
    repeat (4) ord();
    repeat (2) mwr();
    repeat (2) host.wr(1'b1, 1'b1, 9'h000);
    repeat (2) host.rd(1'b1, 1'b1, 1'b1);
    chk(af_n, !((mem.size() - rdp) >= 16384 - (ofs[3] * 512 + ofs[2]) % 16384));
    chk(ae_n, !((mem.size() - rdp) <= (ofs[1] * 512 + ofs[0]) % 16384));
    chk(ff_n, !ft);
    chk(hf_n, 1'b1);
    $display("test offset load and readback done");
    rst(1'b0, 1'b0);
    ord();
    repeat (3) mwr();
    repeat (2) mrd();
    replay();
    chk(ef_n, 1'b1);
    mrd();
    $display("test partial reset and standard replay done");
    rst(1'b1, 1'b1);
    chk(ft_mode, 1'b1);
    ord();
    repeat (3) mwr();
    repeat (3) host.rd(1'b1, 1'b1, 1'b1);
    chk(rd_bus, mem[0]);
    mrd();
    replay();
    chk(rd_bus, mem[0]);
    chk(ef_n, 1'b0);
    chk(ff_n, !ft);
    chk(hf_n, 1'b1);
    $display("test fall-through replay done");
    results();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    results();
  end
endmodule
